// ==== pcds_pkg.sv ====
// Types shared by the clock and datapath setup block
`default_nettype none
package pcds_pkg;
   typedef enum logic [1:0] {
      PCDS_SRC_MUTE,
      PCDS_SRC_LEFT,
      PCDS_SRC_RIGHT,
      PCDS_SRC_MONO
   } pcds_src_t;
endpackage
`default_nettype wire

// ==== pcds_regs.svh ====
// Register offsets, field positions, reset values and timing constants
`ifndef PCDS_REGS_SVH
`define PCDS_REGS_SVH
// ==========================================================================
// Offsets (8-bit register index on the control port)
`define PCDS_OFS_PLL_ENA      8'h03
`define PCDS_OFS_PLL_INT      8'h04
`define PCDS_OFS_FRAC_HI      8'h05
`define PCDS_OFS_FRAC_LO      8'h06
`define PCDS_OFS_DATAPATH     8'h07
// ==========================================================================
// Reset values
`define PCDS_RST_PLL_ENA      8'h10
`define PCDS_RST_PLL_INT      8'h04
`define PCDS_RST_FRAC_HI      8'h00
`define PCDS_RST_FRAC_LO      8'h00
`define PCDS_RST_DATAPATH     8'h00
// ==========================================================================
// Field positions
`define PCDS_ENA_BIT          7
`define PCDS_Q_MSB            6
`define PCDS_Q_LSB            3
`define PCDS_P_MSB            2
`define PCDS_P_LSB            0
`define PCDS_J_MSB            7
`define PCDS_J_LSB            2
`define PCDS_FLO_MSB          7
`define PCDS_FLO_LSB          2
`define PCDS_FSREF_BIT        7
`define PCDS_ADC_DR_BIT       6
`define PCDS_DAC_DR_BIT       5
`define PCDS_LSEL_MSB         4
`define PCDS_LSEL_LSB         3
`define PCDS_RSEL_MSB         2
`define PCDS_RSEL_LSB         1
// Writable masks: reserved bits hold zero
`define PCDS_MASK_PLL_INT     8'hfc
`define PCDS_MASK_FRAC_LO     8'hfc
`define PCDS_MASK_DATAPATH    8'hfe
// ==========================================================================
// Gain-control timer constants, in Hz
`define PCDS_FSREF_48K_HZ     32'd48000
`define PCDS_FSREF_44K1_HZ    32'd44100
`endif

// ==== pcds_route.sv ====
// Maps a 2-bit converter path selector onto a source choice
`timescale 1ns/1ps
`default_nettype none
module pcds_route (
   input  wire logic [1:0]         i_sel,
   input  wire logic               i_swap,
   output pcds_pkg::pcds_src_t     o_src
);
   import pcds_pkg::*;
   // ==========================================================================
   // Selector decode; the right path swaps the meaning of 01 and 10
   assign o_src = (i_sel == 2'h0) ? PCDS_SRC_MUTE :
                  (i_sel == 2'h3) ? PCDS_SRC_MONO :
                  ((i_sel == 2'h1) ^ i_swap) ? PCDS_SRC_LEFT : PCDS_SRC_RIGHT;
endmodule
`default_nettype wire

// ==== pcds_setup.sv ====
// Clock loop and playback datapath setup registers
//
// Contract
// - Fraction upper eight bits from high register
// - Fraction low six bits from bits 7:2
// - Reference rate bit picks timer constant
// - Input converter dual rate follows bit
// - Output converter dual rate follows bit
// - Left path selector mute/left/right/mono
// - Right path selector mute/right/left/mono
`timescale 1ns/1ps
`default_nettype none
`include "pcds_regs.svh"
module pcds_setup (
   input  wire logic               i_clk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_wr_en,
   input  wire logic               i_rd_en,
   input  wire logic [7:0]         i_addr,
   input  wire logic [7:0]         i_wdata,
   output logic      [7:0]         o_rdata,
   output logic                    o_rd_valid,
   output logic                    o_pll_enable,
   output logic      [4:0]         o_pll_div_q,
   output logic      [3:0]         o_pll_div_p,
   output logic      [5:0]         o_pll_mult_j,
   output logic      [13:0]        o_pll_frac_d,
   output logic      [31:0]        o_agc_fsref_hz,
   output logic                    o_adc_dual_rate,
   output logic                    o_dac_dual_rate,
   output pcds_pkg::pcds_src_t     o_left_src,
   output pcds_pkg::pcds_src_t     o_right_src
);
   import pcds_pkg::*;

   // ==========================================================================
   // Decode helpers
   function automatic logic [4:0] dec_q(input logic [3:0] c);
      dec_q = (c == 4'h0) ? 5'h10 : (c == 4'h1) ? 5'h11 : {1'b0, c};
   endfunction
   function automatic logic [3:0] dec_p(input logic [2:0] c);
      dec_p = (c == 3'h0) ? 4'h8 : {1'b0, c};
   endfunction

   // ==========================================================================
   // Register file
   logic [7:0] ena_q;
   logic [7:0] int_q;
   logic [7:0] fhi_q;
   logic [7:0] flo_q;
   logic [7:0] dp_q;
   // Fraction high byte is staged so the loop sees a whole new value only
   // once the low byte lands; avoids a transient mixed fraction.
   logic [7:0] fhi_stage_q;

   wire wr_ena = i_wr_en && (i_addr == `PCDS_OFS_PLL_ENA);
   wire wr_int = i_wr_en && (i_addr == `PCDS_OFS_PLL_INT);
   wire wr_fhi = i_wr_en && (i_addr == `PCDS_OFS_FRAC_HI);
   wire wr_flo = i_wr_en && (i_addr == `PCDS_OFS_FRAC_LO);
   wire wr_dp  = i_wr_en && (i_addr == `PCDS_OFS_DATAPATH);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ena_q       <= `PCDS_RST_PLL_ENA;
         int_q       <= `PCDS_RST_PLL_INT;
         fhi_q       <= `PCDS_RST_FRAC_HI;
         fhi_stage_q <= `PCDS_RST_FRAC_HI;
         flo_q       <= `PCDS_RST_FRAC_LO;
         dp_q        <= `PCDS_RST_DATAPATH;
      end else begin
         if (wr_ena) ena_q <= i_wdata;
         if (wr_int) int_q <= i_wdata & `PCDS_MASK_PLL_INT;
         if (wr_fhi) fhi_stage_q <= i_wdata;
         if (wr_flo) begin
            flo_q <= i_wdata & `PCDS_MASK_FRAC_LO;
            fhi_q <= fhi_stage_q;
         end
         if (wr_dp) dp_q <= i_wdata & `PCDS_MASK_DATAPATH;
      end
   end

   // ==========================================================================
   // Read port: one-cycle latency, unmapped offsets read zero
   wire [7:0] rd_mux = (i_addr == `PCDS_OFS_PLL_ENA)  ? ena_q :
                       (i_addr == `PCDS_OFS_PLL_INT)  ? int_q :
                       (i_addr == `PCDS_OFS_FRAC_HI)  ? fhi_stage_q :
                       (i_addr == `PCDS_OFS_FRAC_LO)  ? flo_q :
                       (i_addr == `PCDS_OFS_DATAPATH) ? dp_q : 8'h00;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_rdata    <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_rdata    <= i_rd_en ? rd_mux : 8'h00;
         o_rd_valid <= i_rd_en;
      end
   end

   // ==========================================================================
   // Decoded controls, registered onto the outputs
   pcds_src_t left_src;
   pcds_src_t right_src;

   pcds_route u_left (
      .i_sel  (dp_q[`PCDS_LSEL_MSB:`PCDS_LSEL_LSB]),
      .i_swap (1'b0),
      .o_src  (left_src)
   );
   pcds_route u_right (
      .i_sel  (dp_q[`PCDS_RSEL_MSB:`PCDS_RSEL_LSB]),
      .i_swap (1'b1),
      .o_src  (right_src)
   );

   wire [31:0] fsref_d = dp_q[`PCDS_FSREF_BIT] ? `PCDS_FSREF_44K1_HZ
                                               : `PCDS_FSREF_48K_HZ;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_pll_enable    <= 1'b0;
         o_pll_div_q     <= 5'h02;
         o_pll_div_p     <= 4'h8;
         o_pll_mult_j    <= 6'h01;
         o_pll_frac_d    <= 14'h0000;
         o_agc_fsref_hz  <= `PCDS_FSREF_48K_HZ;
         o_adc_dual_rate <= 1'b0;
         o_dac_dual_rate <= 1'b0;
         o_left_src      <= PCDS_SRC_MUTE;
         o_right_src     <= PCDS_SRC_MUTE;
      end else begin
         o_pll_enable    <= ena_q[`PCDS_ENA_BIT];
         o_pll_div_q     <= dec_q(ena_q[`PCDS_Q_MSB:`PCDS_Q_LSB]);
         o_pll_div_p     <= dec_p(ena_q[`PCDS_P_MSB:`PCDS_P_LSB]);
         o_pll_mult_j    <= int_q[`PCDS_J_MSB:`PCDS_J_LSB];
         o_pll_frac_d    <= {fhi_q, flo_q[`PCDS_FLO_MSB:`PCDS_FLO_LSB]};
         o_agc_fsref_hz  <= fsref_d;
         o_adc_dual_rate <= dp_q[`PCDS_ADC_DR_BIT];
         o_dac_dual_rate <= dp_q[`PCDS_DAC_DR_BIT];
         o_left_src      <= left_src;
         o_right_src     <= right_src;
      end
   end

   // ==========================================================================
   // Checks
   // Decoded outputs lag a write by two edges: the register, then the output flop
   sequence s_flo_write;
      wr_flo && !i_sys_rst;
   endsequence
   sequence s_frac_visible;
      ##2 o_pll_frac_d[13:6] == $past(fhi_stage_q, 2);
   endsequence
   // A lone high-byte write must not move the loop, or a half-new fraction leaks out
   sequence s_fhi_alone;
      wr_fhi ##1 !wr_flo;
   endsequence

   pll_enable_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_ena ##1 1 |-> ##1 o_pll_enable == $past(i_wdata[7], 2))
      else $error("loop enable does not follow its bit");
   pll_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_ena && !i_wdata[7] |-> ##2 !o_pll_enable)
      else $error("loop still enabled after clear");
   div_q_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ##1 o_pll_div_q == ({1'b0, $past(ena_q[6:3])}
                          + (($past(ena_q[6:3]) < 4'h2) ? 5'h10 : 5'h00)))
      else $error("divider decode wrong");
   div_p_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ##1 o_pll_div_p == (($past(ena_q[2:0]) == 3'h0) ? 4'h8 : {1'b0, $past(ena_q[2:0])}))
      else $error("prescaler decode wrong");
   mult_int_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_int |-> ##2 o_pll_mult_j == $past(i_wdata[7:2], 2))
      else $error("multiplier output does not follow write");
   frac_high_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_flo_write |-> s_frac_visible)
      else $error("fraction upper byte not taken on low write");
   frac_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_fhi_alone |-> ##1 $stable(o_pll_frac_d))
      else $error("fraction moved on a lone high write");
   frac_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_flo |-> ##1 flo_q[1:0] == 2'h0 ##1 o_pll_frac_d[5:0] == $past(flo_q[7:2]))
      else $error("fraction lower bits wrong");
   fsref_sel_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ##1 o_agc_fsref_hz == ($past(dp_q[7]) ? `PCDS_FSREF_44K1_HZ : `PCDS_FSREF_48K_HZ))
      else $error("reference rate constant wrong");
   adc_dual_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp |-> ##2 o_adc_dual_rate == $past(i_wdata[6], 2))
      else $error("input converter dual rate wrong");
   dac_dual_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp |-> ##2 o_dac_dual_rate == $past(i_wdata[5], 2))
      else $error("output converter dual rate wrong");
   left_mute_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[4:3] == 2'h0 |-> ##2 o_left_src == PCDS_SRC_MUTE)
      else $error("left path not muted");
   left_own_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[4:3] == 2'h1 |-> ##2 o_left_src == PCDS_SRC_LEFT)
      else $error("left path does not play left data");
   left_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[4:3] == 2'h2 |-> ##2 o_left_src == PCDS_SRC_RIGHT)
      else $error("left path routing wrong");
   left_mono_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[4:3] == 2'h3 |-> ##2 o_left_src == PCDS_SRC_MONO)
      else $error("left path mono mix wrong");
   right_own_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[2:1] == 2'h1 |-> ##2 o_right_src == PCDS_SRC_RIGHT)
      else $error("right path does not play right data");
   right_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[2:1] == 2'h2 |-> ##2 o_right_src == PCDS_SRC_LEFT)
      else $error("right path routing wrong");
   right_mono_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_dp && i_wdata[2:1] == 2'h3 |-> ##2 o_right_src == PCDS_SRC_MONO)
      else $error("right path mono mix wrong");
endmodule
`default_nettype wire

// ==== tb_pcds_setup.sv ====
// Self-checking testbench for the clock loop and datapath setup block
`timescale 1ns/1ps
`default_nettype none
`include "pcds_regs.svh"
module tb_pcds_setup;
   import pcds_pkg::*;
   logic        i_clk, i_sys_rst, i_wr_en, i_rd_en;
   logic [7:0]  i_addr, i_wdata, o_rdata, v;
   logic        o_rd_valid, o_pll_enable, o_adc_dual_rate, o_dac_dual_rate;
   logic [4:0]  o_pll_div_q;
   logic [3:0]  o_pll_div_p;
   logic [5:0]  o_pll_mult_j;
   logic [13:0] o_pll_frac_d;
   logic [31:0] o_agc_fsref_hz;
   pcds_src_t   o_left_src, o_right_src;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles = 0;
   pcds_setup pcds_setup_inst (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
      .o_pll_enable(o_pll_enable), .o_pll_div_q(o_pll_div_q), .o_pll_div_p(o_pll_div_p),
      .o_pll_mult_j(o_pll_mult_j), .o_pll_frac_d(o_pll_frac_d),
      .o_agc_fsref_hz(o_agc_fsref_hz), .o_adc_dual_rate(o_adc_dual_rate),
      .o_dac_dual_rate(o_dac_dual_rate), .o_left_src(o_left_src), .o_right_src(o_right_src));
   // ==========================================
   // Clock and hang guard
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         $display("ERROR at %0t: timeout", $time);
         complete_run();
      end
   end
   // ==========================================
   // Access tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   // Controls settle one edge after the write is taken; the task waits two
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      int k;
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1;
      for (k = 0; k < 3 && o_rd_valid !== 1'b1; k++) @(posedge i_clk) #1;
      chk(o_rd_valid, 1, what);
      chk(o_rdata, exp, what);
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      i_sys_rst = 1'b1;
      i_wr_en = 1'b0;
      i_rd_en = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk(o_pll_enable, 0, "enable");
      chk({o_pll_div_q, o_pll_div_p}, {5'd2, 4'd8}, "q p");
      chk(o_pll_mult_j, 1, "j");
      chk(o_pll_frac_d, 0, "frac");
      chk(o_agc_fsref_hz, `PCDS_FSREF_48K_HZ, "fsref");
      chk({o_adc_dual_rate, o_dac_dual_rate}, 0, "dual");
      chk({o_left_src, o_right_src}, 0, "src");
      rd(`PCDS_OFS_PLL_ENA, `PCDS_RST_PLL_ENA, "rst ena");
      rd(`PCDS_OFS_PLL_INT, `PCDS_RST_PLL_INT, "rst int");
      rd(`PCDS_OFS_FRAC_HI, `PCDS_RST_FRAC_HI, "rst hi");
      rd(`PCDS_OFS_FRAC_LO, `PCDS_RST_FRAC_LO, "rst lo");
      rd(`PCDS_OFS_DATAPATH, `PCDS_RST_DATAPATH, "rst dp");
      rd(8'h02, 8'h00, "unmapped");
      $display("Test reset values done");
      for (int i = 0; i < 16; i++) begin
         v = {i[0], i[3:0], i[2:0]};
         wr(`PCDS_OFS_PLL_ENA, v);
         chk(o_pll_enable, i[0], "enable");
         chk(o_pll_div_q, (i < 2) ? i + 16 : i, "q");
         chk(o_pll_div_p, (i % 8 == 0) ? 8 : i % 8, "p");
         rd(`PCDS_OFS_PLL_ENA, v, "ena readback");
      end
      $display("Test divider decode done");
      for (int j = 1; j < 64; j += 31) begin
         wr(`PCDS_OFS_PLL_INT, {j[5:0], 2'b00});
         chk(o_pll_mult_j, j, "j");
         rd(`PCDS_OFS_PLL_INT, {j[5:0], 2'b00}, "int readback");
      end
      $display("Test multiplier done");
      wr(`PCDS_OFS_FRAC_HI, 8'h9c);
      chk(o_pll_frac_d, 0, "staged");
      wr(`PCDS_OFS_FRAC_LO, 8'h3f);
      chk(o_pll_frac_d, 14'd9999, "frac max");
      rd(`PCDS_OFS_FRAC_HI, 8'h9c, "hi readback");
      rd(`PCDS_OFS_FRAC_LO, 8'h3c, "lo readback");
      wr(`PCDS_OFS_FRAC_HI, 8'h01);
      chk(o_pll_frac_d, 14'd9999, "hi held");
      wr(`PCDS_OFS_FRAC_LO, 8'h04);
      chk(o_pll_frac_d, 14'd65, "frac mid");
      wr(`PCDS_OFS_FRAC_HI, 8'h01);
      wr(`PCDS_OFS_FRAC_LO, 8'h08);
      chk(o_pll_frac_d, 14'd66, "frac low only");
      $display("Test fraction done");
      for (int i = 0; i < 16; i++) begin
         v = {i[0], i[1], i[1], i[3:2], i[1:0], 1'b0};
         wr(`PCDS_OFS_DATAPATH, v);
         chk(o_agc_fsref_hz, i[0] ? `PCDS_FSREF_44K1_HZ : `PCDS_FSREF_48K_HZ, "fsref");
         chk(o_adc_dual_rate, i[1], "adc dual");
         chk(o_dac_dual_rate, i[1], "dac dual");
         chk(o_left_src, i[3:2], "left");
         chk(o_right_src, (i % 4 == 1) ? 2 : (i % 4 == 2) ? 1 : i % 4, "right");
         rd(`PCDS_OFS_DATAPATH, v & 8'hfe, "dp readback");
      end
      wr(8'h08, 8'hff);
      rd(`PCDS_OFS_DATAPATH, v & 8'hfe, "after unmapped write");
      rd(8'h08, 8'h00, "unmapped read");
      $display("Test datapath done");
      complete_run();
   end
endmodule
`default_nettype wire
